// >>> hw/clock_speed_pkg.sv
// constants for the double-speed clock generator: register address, field
// positions, reset value and machine-cycle counts.
// assumes one oscillator clock drives everything; each edge is one oscillator period.
// Summary of operation
// RULE1: double speed gives 6 oscillator periods per machine cycle, standard gives 12.
// RULE2: divide-by-two stage feeds core phases; cpu double-speed bit bypasses it.
// RULE3: after reset run standard speed, cpu bit clear, unless boot option programmed.
// RULE4: programmed boot double-speed option starts the device in double speed after reset.
// RULE5: cpu double-speed bit alone speeds up only the cpu clock; here, with all selects clear, it speeds up all six peripherals too.
// RULE6: each of six peripherals runs double speed only while its select bit is clear.
// RULE7: cpu double-speed bit change applied only on divided-clock rising edge.
// RULE8: double-speed peripherals see their time reference halved, events twice as often.
// RULE9: peripheral select clear gives 6 periods per peripheral cycle, set gives 12.
// RULE10: peripheral selects only act while cpu double-speed bit is set.
// RULE11: software never writes one to the reserved top bit of the control register.
// RULE12: peripheral select changes take effect on the same divided-clock rising edge.
package clock_speed_pkg;

	localparam logic [7:0] CLOCK_SPEED_CONTROL_ADDR = 8'h8F;
	localparam logic [7:0] CLOCK_SPEED_CONTROL_RESET = 8'h00;
	// top bit is reserved: never stored, reads zero
	localparam logic [7:0] CLOCK_SPEED_CONTROL_WMASK = 8'h7F;

	localparam int CPU_DOUBLE_SPEED_BIT = 0;
	localparam int TIMER0_SPEED_SELECT_BIT = 1;
	localparam int TIMER1_SPEED_SELECT_BIT = 2;
	localparam int TIMER2_SPEED_SELECT_BIT = 3;
	localparam int UART_SPEED_SELECT_BIT = 4;
	localparam int COUNTER_ARRAY_SPEED_SELECT_BIT = 5;
	localparam int WATCHDOG_SPEED_SELECT_BIT = 6;

	// peripheral tick vector index; index i uses control bit i+1
	localparam int PERIPH_COUNT = 6;
	localparam int PERIPH_TIMER0 = 0;
	localparam int PERIPH_TIMER1 = 1;
	localparam int PERIPH_TIMER2 = 2;
	localparam int PERIPH_UART = 3;
	localparam int PERIPH_COUNTER_ARRAY = 4;
	localparam int PERIPH_WATCHDOG = 5;

	// oscillator periods per machine cycle, for reference by the bench
	localparam int DOUBLE_SPEED_PERIODS = 6;
	localparam int STANDARD_SPEED_PERIODS = 12;
	// phase-generator steps per machine cycle
	localparam logic [2:0] PHASE_LAST = 3'h5;
	localparam logic [2:0] PHASE_FIRST = 3'h0;

	typedef enum logic [1:0] {
		BOOT_SYNC0 = 2'b00,
		BOOT_SYNC1 = 2'b01,
		BOOT_APPLY = 2'b10,
		BOOT_RUN = 2'b11
	} boot_state_type;

endpackage : clock_speed_pkg

// >>> hw/phase_cycle_counter.sv
// counts phase-generator steps and marks the end of each machine cycle.
// assumes phase_en_i comes from logic on ref_clk_i.
`timescale 1ns/1ps
`default_nettype none

module phase_cycle_counter (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic phase_en_i,
	output logic cycle_end_o
);

	logic [2:0] phase_q;
	logic [2:0] phase_d;
	logic cycle_end_q;
	logic cycle_end_d;

	always_comb begin
		phase_d = phase_q;
		cycle_end_d = 1'b0;
		if (phase_en_i) begin
			if (phase_q == clock_speed_pkg::PHASE_LAST) begin
				phase_d = clock_speed_pkg::PHASE_FIRST;
				cycle_end_d = 1'b1;
			end else begin
				phase_d = phase_q + 3'h1;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phase_q <= clock_speed_pkg::PHASE_FIRST;
			cycle_end_q <= 1'b0;
		end else begin
			phase_q <= phase_d;
			cycle_end_q <= cycle_end_d;
		end
	end

	assign cycle_end_o = cycle_end_q;

endmodule : phase_cycle_counter

`default_nettype wire

// >>> hw/double_speed_clock_gen.sv
// clock generation: divide-by-two oscillator stage, cpu double-speed bypass,
// per-peripheral speed selection and the clock speed control register.
// assumes ref_clk_i is the oscillator input; outputs are enables on that clock.
// the control register is reached over the special-function-register port.
`timescale 1ns/1ps
`default_nettype none

module double_speed_clock_gen (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic boot_double_speed_option_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	output logic sfr_sel_o,
	output logic running_o,
	output logic osc_half_o,
	output logic cpu_double_speed_o,
	output logic core_phase_en_o,
	output logic machine_cycle_o,
	output logic [5:0] periph_phase_en_o,
	output logic [5:0] periph_tick_o
);

	function automatic logic sfr_hit(input logic [7:0] addr);
		sfr_hit = (addr == clock_speed_pkg::CLOCK_SPEED_CONTROL_ADDR);
	endfunction : sfr_hit

	// a clock running double speed steps every oscillator period,
	// otherwise only on the rising edge of the divided clock
	function automatic logic phase_step(input logic double_speed, input logic half_rise);
		phase_step = double_speed | half_rise;
	endfunction : phase_step

	// select bit clear means double speed, but only under the cpu bit;
	// with the cpu bit clear every clock stays at standard speed
	function automatic logic periph_fast(input logic cpu_bit, input logic sel_bit);
		periph_fast = cpu_bit & ~sel_bit;
	endfunction : periph_fast

	// boot option synchroniser and start-up sequence
	// the option is not on this clock, so two flops stand before any logic reads it
	logic boot_meta_q;
	logic boot_meta_d;
	logic boot_sync_q;
	logic boot_sync_d;
	clock_speed_pkg::boot_state_type boot_state_q;
	clock_speed_pkg::boot_state_type boot_state_d;

	always_comb begin
		boot_meta_d = boot_double_speed_option_i;
		boot_sync_d = boot_meta_q;
		boot_state_d = boot_state_q;
		unique case (boot_state_q)
			clock_speed_pkg::BOOT_SYNC0: begin
				boot_state_d = clock_speed_pkg::BOOT_SYNC1;
			end
			clock_speed_pkg::BOOT_SYNC1: begin
				boot_state_d = clock_speed_pkg::BOOT_APPLY;
			end
			clock_speed_pkg::BOOT_APPLY: begin
				boot_state_d = clock_speed_pkg::BOOT_RUN;
			end
			clock_speed_pkg::BOOT_RUN: begin
				boot_state_d = clock_speed_pkg::BOOT_RUN;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			boot_meta_q <= 1'b0;
			boot_sync_q <= 1'b0;
			boot_state_q <= clock_speed_pkg::BOOT_SYNC0;
		end else begin
			boot_meta_q <= boot_meta_d;
			boot_sync_q <= boot_sync_d;
			boot_state_q <= boot_state_d;
		end
	end

	logic running;
	logic boot_apply;

	// nothing steps and no write lands until start-up has loaded both copies
	assign running = (boot_state_q == clock_speed_pkg::BOOT_RUN);
	assign boot_apply = (boot_state_q == clock_speed_pkg::BOOT_APPLY);

	// divide-by-two stage
	// free running from reset so its phase is known when the clocks start
	logic half_q;
	logic half_d;
	logic half_rise;

	always_comb begin
		half_d = ~half_q; // [RULE2]
	end

	// the divided clock rises at the next edge exactly when it is low now
	assign half_rise = ~half_q;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			half_q <= 1'b0;
		end else begin
			half_q <= half_d;
		end
	end

	// control register: software copy and the copy the clocks obey
	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic [7:0] eff_q;
	logic [7:0] eff_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	always_comb begin
		ctrl_d = ctrl_q;
		eff_d = eff_q;
		rdata_d = 8'h00;
		if (boot_apply) begin
			// start-up comes in standard speed unless the boot option says otherwise
			ctrl_d = clock_speed_pkg::CLOCK_SPEED_CONTROL_RESET; // [RULE3]
			ctrl_d[clock_speed_pkg::CPU_DOUBLE_SPEED_BIT] = boot_sync_q; // [RULE4]
			// clocks are still held here, so no glitch from loading directly
			eff_d = ctrl_d;
		end else if (running) begin
			if (sfr_wr_i && sfr_hit(sfr_addr_i)) begin
				// reserved bit dropped even if software misbehaves
				ctrl_d = sfr_wdata_i & clock_speed_pkg::CLOCK_SPEED_CONTROL_WMASK; // [RULE11]
			end
			// mode and select changes only land on a divided-clock rising edge
			if (half_rise) begin
				eff_d = ctrl_q; // [RULE7] [RULE12]
			end
		end
		// reads show the software copy, so a write is seen back at once;
		// the clocks may still obey the old value for up to two more periods
		if (sfr_rd_i && sfr_hit(sfr_addr_i)) begin
			rdata_d = ctrl_q;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_q <= clock_speed_pkg::CLOCK_SPEED_CONTROL_RESET; // [RULE3]
			eff_q <= clock_speed_pkg::CLOCK_SPEED_CONTROL_RESET;
			rdata_q <= 8'h00;
		end else begin
			ctrl_q <= ctrl_d;
			eff_q <= eff_d;
			rdata_q <= rdata_d;
		end
	end

	// phase enables for the cpu and each peripheral
	logic cpu_x2;
	logic cpu_step;
	logic [5:0] periph_x2;
	logic [5:0] periph_step;
	logic cpu_step_q;
	logic [5:0] periph_step_q;

	// cpu bit also gates the peripheral selects: with a select clear it speeds that peripheral too
	assign cpu_x2 = eff_q[clock_speed_pkg::CPU_DOUBLE_SPEED_BIT]; // [RULE5]
	// held until start-up done so the core never runs in the wrong mode
	assign cpu_step = running & phase_step(cpu_x2, half_rise); // [RULE1] [RULE2]

	always_comb begin
		periph_x2 = 6'h00;
		periph_step = 6'h00;
		for (int i = 0; i < clock_speed_pkg::PERIPH_COUNT; i++) begin
			// control bit i+1 belongs to peripheral i
			periph_x2[i] = periph_fast(cpu_x2, eff_q[i + 1]); // [RULE6] [RULE9] [RULE10]
			// double speed halves the time reference
			periph_step[i] = running & phase_step(periph_x2[i], half_rise); // [RULE8]
		end
	end

	// registered copies hand the core and peripherals clean enables
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cpu_step_q <= 1'b0;
			periph_step_q <= 6'h00;
		end else begin
			cpu_step_q <= cpu_step;
			periph_step_q <= periph_step;
		end
	end

	// machine cycle = six phase steps: 6 periods in double speed, 12 otherwise
	phase_cycle_counter cpu_cycle (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.phase_en_i(cpu_step), // [RULE1]
		.cycle_end_o(machine_cycle_o)
	);

	// one counter per peripheral: its cycle never depends on the core's phase
	for (genvar g = 0; g < clock_speed_pkg::PERIPH_COUNT; g++) begin : g_periph
		phase_cycle_counter periph_cycle (
			.ref_clk_i(ref_clk_i),
			.rst_n_i(rst_n_i),
			.phase_en_i(periph_step[g]), // [RULE9]
			.cycle_end_o(periph_tick_o[g])
		);
	end

	assign sfr_rdata_o = rdata_q;
	assign sfr_sel_o = sfr_hit(sfr_addr_i);
	assign running_o = running;
	assign osc_half_o = half_q;
	// the applied copy is what the clocks obey, so that is the mode shown outside
	assign cpu_double_speed_o = eff_q[clock_speed_pkg::CPU_DOUBLE_SPEED_BIT];
	assign core_phase_en_o = cpu_step_q;
	assign periph_phase_en_o = periph_step_q;

endmodule : double_speed_clock_gen

`default_nettype wire

// >>> dv/double_speed_clock_gen_asserts.sv
// checker for the clock generator: cadence, mode switch, register port.
// assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module double_speed_clock_gen_asserts (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic boot_double_speed_option_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic sfr_sel_o,
	input wire logic running_o,
	input wire logic osc_half_o,
	input wire logic cpu_double_speed_o,
	input wire logic core_phase_en_o,
	input wire logic machine_cycle_o,
	input wire logic [5:0] periph_phase_en_o
);
default clocking @(posedge ref_clk_i); endclocking
default disable iff (!rst_n_i);
logic [4:0] gap_q;
logic [1:0] ok_q;
// first cycle after a switch may be partial, so trust gaps later
always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		gap_q <= 5'h00;
		ok_q <= 2'h0;
	end else begin
		gap_q <= machine_cycle_o ? 5'h01 : gap_q + 5'h01;
		if ($changed(cpu_double_speed_o))
			ok_q <= 2'h0;
		else if (machine_cycle_o && ok_q != 2'h3)
			ok_q <= ok_q + 2'h1;
	end
end
chk_cycle_len: assert property (machine_cycle_o && ok_q == 2'h3 |->
	gap_q == (cpu_double_speed_o ? 5'h06 : 5'h0C)) else $error("machine cycle length");
chk_fast_step: assert property (cpu_double_speed_o && ok_q == 2'h3 |->
	core_phase_en_o) else $error("missing fast step");
chk_slow_step: assert property (!cpu_double_speed_o && ok_q == 2'h3 && core_phase_en_o
	|=> !core_phase_en_o) else $error("slow step too close");
chk_switch_edge: assert property (running_o && $past(running_o)
	&& $changed(cpu_double_speed_o) |-> $rose(osc_half_o)) else $error("switch off edge");
chk_half_toggle: assert property (running_o |=> $changed(osc_half_o))
	else $error("divided clock stuck");
chk_boot_mode: assert property ($rose(running_o) |->
	cpu_double_speed_o == boot_double_speed_option_i) else $error("start mode");
chk_sel_decode: assert property (sfr_sel_o ==
	(sfr_addr_i == clock_speed_pkg::CLOCK_SPEED_CONTROL_ADDR)) else $error("address decode");
chk_rd_idle: assert property (!(sfr_rd_i && sfr_sel_o) |=> sfr_rdata_o == 8'h00)
	else $error("read data not idle");
chk_rd_top: assert property (sfr_rd_i && sfr_sel_o |=> !sfr_rdata_o[7])
	else $error("reserved bit read");
chk_periph_std: assert property (!$past(cpu_double_speed_o) |->
	periph_phase_en_o == {6{core_phase_en_o}}) else $error("select acts in standard mode");
chk_rise_steps: assert property ($past(running_o) && $rose(osc_half_o) |->
	core_phase_en_o && periph_phase_en_o == 6'h3F) else $error("step lost on divided rise");
cover property (running_o && cpu_double_speed_o && periph_phase_en_o != 6'h3F);
cover property (machine_cycle_o && ok_q == 2'h3 && cpu_double_speed_o);
cover property (machine_cycle_o && ok_q == 2'h3 && !cpu_double_speed_o);
cover property (running_o && $fell(cpu_double_speed_o));
endmodule : double_speed_clock_gen_asserts
bind double_speed_clock_gen double_speed_clock_gen_asserts u_double_speed_clock_gen_asserts (
	.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
	.boot_double_speed_option_i(boot_double_speed_option_i), .sfr_addr_i(sfr_addr_i),
	.sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o), .sfr_sel_o(sfr_sel_o),
	.running_o(running_o), .osc_half_o(osc_half_o), .cpu_double_speed_o(cpu_double_speed_o),
	.core_phase_en_o(core_phase_en_o), .machine_cycle_o(machine_cycle_o),
	.periph_phase_en_o(periph_phase_en_o));
`default_nettype wire

// >>> dv/clock_sink_model.sv
// core and peripheral clock sink: measures spacing of cycle pulses.
// assumes one pulse per machine or peripheral cycle on the oscillator clock.
`timescale 1ns/1ps
`default_nettype none
module clock_sink_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [6:0] tick_i,
	output logic [6:0][4:0] gap_o
);
logic [6:0][4:0] cnt_q;
always_ff @(posedge clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		cnt_q <= '0;
		gap_o <= '0;
	end else begin
		for (int i = 0; i < 7; i++) begin
			if (tick_i[i]) begin
				gap_o[i] <= cnt_q[i] + 5'h01;
				cnt_q[i] <= 5'h00;
			end else if (cnt_q[i] != 5'h1F) begin
				// saturate so a long stall cannot wrap to a plausible count
				cnt_q[i] <= cnt_q[i] + 5'h01;
			end
		end
	end
end
endmodule : clock_sink_model
`default_nettype wire

// >>> dv/double_speed_clock_gen_tb.sv
// testbench: reset, boot option, register writes and clock cadences.
// assumes the sink model reports the last pulse spacing per clock.
`timescale 1ns/1ps
`default_nettype none
module double_speed_clock_gen_tb;
logic ref_clk_i = 1'b0;
logic rst_n_i = 1'b0;
logic boot = 1'b0;
logic wr = 1'b0;
logic rd = 1'b0;
logic [7:0] addr = 8'h8F;
logic [7:0] wdata = 8'h00;
logic [7:0] rdata;
logic cpu_ds;
logic mc;
logic [5:0] tick;
logic [6:0][4:0] gap;
// bit 7 always kept clear
logic [7:0] modes [6] = '{8'h01, 8'h7F, 8'h2B, 8'h55, 8'h7E, 8'h00};
int failures = 0;
int cmp_count = 0;
always #2 ref_clk_i = ~ref_clk_i;
double_speed_clock_gen u_double_speed_clock_gen (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
	.boot_double_speed_option_i(boot), .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd),
	.sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .sfr_sel_o(), .running_o(), .osc_half_o(),
	.cpu_double_speed_o(cpu_ds), .core_phase_en_o(), .machine_cycle_o(mc),
	.periph_phase_en_o(), .periph_tick_o(tick));
clock_sink_model u_clock_sink_model (.clk_i(ref_clk_i), .rst_n_i(rst_n_i),
	.tick_i({mc, tick}), .gap_o(gap));
task check(input logic [7:0] seen, input logic [7:0] exp);
	cmp_count++;
	if (seen !== exp) begin
		failures++;
		$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
	end
endtask : check
task stop_test;
	$display("compares %0d mismatches %0d", cmp_count, failures);
	if (failures == 0 && cmp_count > 0)
		$display("Run complete: PASS");
	else
		$display("Run complete: FAIL");
	$finish;
endtask : stop_test
// one strobe cycle; read data is registered, so it is sampled after the strobe drops
task sfr_op(input logic [7:0] a, input logic [7:0] d, input logic w);
	@(negedge ref_clk_i);
	addr = a;
	wdata = d;
	wr = w;
	rd = !w;
	@(negedge ref_clk_i);
	wr = 1'b0;
	rd = 1'b0;
endtask : sfr_op
task do_reset(input logic b);
	rst_n_i = 1'b0;
	boot = b;
	repeat (2) @(negedge ref_clk_i);
	rst_n_i = 1'b1;
	repeat (4) @(negedge ref_clk_i);
endtask : do_reset
task expect_speed(input logic [7:0] v);
	repeat (40) @(negedge ref_clk_i);
	check({7'h00, cpu_ds}, {7'h00, v[0]});
	check({3'h0, gap[6]}, v[0] ? 8'h06 : 8'h0C);
	for (int i = 0; i < 6; i++) begin
		check({3'h0, gap[i]}, (v[0] && !v[i+1]) ? 8'h06 : 8'h0C);
	end
endtask : expect_speed
task t_mode(input logic [7:0] v);
	sfr_op(8'h8F, v, 1'b1);
	sfr_op(8'h8F, 8'h00, 1'b0);
	check(rdata, v & 8'h7F);
	expect_speed(v);
	$display("test mode %h done", v);
endtask : t_mode
initial begin
	do_reset(1'b0);
	sfr_op(8'h8F, 8'h00, 1'b0);
	check(rdata, 8'h00);
	expect_speed(8'h00);
	sfr_op(8'h8E, 8'h01, 1'b1);
	sfr_op(8'h8E, 8'h00, 1'b0);
	check(rdata, 8'h00);
	expect_speed(8'h00);
	$display("test reset and unmapped done");
	foreach (modes[k]) t_mode(modes[k]);
	do_reset(1'b1);
	sfr_op(8'h8F, 8'h00, 1'b0);
	check(rdata, 8'h01);
	expect_speed(8'h01);
	$display("test boot option done");
	do_reset(1'b0);
	sfr_op(8'h8F, 8'h00, 1'b0);
	check(rdata, 8'h00);
	expect_speed(8'h00);
	$display("test warm reset done");
	stop_test();
end
initial begin
	repeat (4000) @(posedge ref_clk_i);
	failures++;
	stop_test();
end
endmodule : double_speed_clock_gen_tb
`default_nettype wire
